// >>> logic/brc_ctrl.sv
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "brc_regs.svh"

module brc_ctrl #(
  parameter int FILT_CYC = `BRC_FILT_CYC
) (
  // clock, reset, clock enable
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // register bus
  input wire brc_pkg::brc_apb_req_t apb_i,
  output brc_pkg::brc_apb_rsp_t apb_o,
  // analog monitor pins, asynchronous
  input wire logic por_mon_i,
  input wire logic supply_low_i,
  input wire logic mon_ready_i,
  // system state, same clock
  input wire logic sleep_i,
  input wire logic bulk_erase_i,
  // monitor control
  output logic mon_enable_o,
  output logic mon_hibernate_o,
  output logic [3:0] brownout_threshold_o,
  // reset and start-up gating
  output logic dev_reset_o,
  output logic cpu_run_o,
  output logic power_up_delay_start_o,
  output logic erase_abort_o,
  // interrupt
  output logic irq_o
);

  generate
    if (FILT_CYC < 1) begin : g_bad
      $error("brc_ctrl: FILT_CYC must be at least 1");
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [1:0] sync_por;
    logic [1:0] sync_low;
    logic [1:0] sync_rdy;
    brc_pkg::brc_state_t fsm;
    brc_pkg::brc_cfg_t cfg;
    logic por_flag_n;
    logic brownout_cause_flag_n;
    brc_pkg::brc_irq_t irq_st;
    brc_pkg::brc_irq_t irq_mask;
    logic rdy_q;
    logic trip_q;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic mon_en;
    logic mon_hib;
    logic [3:0] thr;
    logic dev_reset;
    logic cpu_run;
    logic pud_start;
    logic abort;
    logic irq;
  } brc_st_t;

  brc_st_t st_r;
  brc_st_t st_nxt;

  logic trip;
  logic filt_low;

  //////////////////////////////////////////////////////////////////////////////
  // combinational helpers

  logic por_act;
  logic low;
  logic brownout_ready_flag;
  logic asleep;
  logic active;
  logic hibernate;
  logic protect;
  logic start_wait;
  logic setup;
  logic access;
  logic hit;
  brc_pkg::brc_irq_t ev;
  logic [31:0] rd;
  logic rd_err;

  // synchronised pin levels: only the second stage is used
  assign por_act = st_r.sync_por[1];
  assign low = st_r.sync_low[1];
  assign brownout_ready_flag = st_r.sync_rdy[1];
  assign asleep = (st_r.fsm == brc_pkg::BRC_ST_SLEEP);
  assign setup = apb_i.psel && !apb_i.penable;
  assign access = apb_i.psel && apb_i.penable && st_r.pready;

  // monitor mode decode; erase overrides every configured mode
  always_comb begin
    active = 1'b0;
    hibernate = 1'b0;
    case (st_r.cfg.brownout_mode_select)
      brc_pkg::BRC_MODE_ON: begin
        active = 1'b1;
      end
      brc_pkg::BRC_MODE_SLEEP_OFF: begin
        active = !asleep;
        hibernate = asleep;
      end
      brc_pkg::BRC_MODE_SOFT: begin
        // sleep is not looked at here, only the software bit
        active = st_r.cfg.brownout_soft_enable;
        hibernate = !st_r.cfg.brownout_soft_enable;
      end
      default: begin
        active = 1'b0;
      end
    endcase
    if (bulk_erase_i) begin
      active = 1'b1;
      hibernate = 1'b0;
    end
  end

  // protection needs a ready monitor, whatever enabled it
  assign protect = active && brownout_ready_flag;
  assign filt_low = low && protect;

  // a tripped filter resets the device unless an erase is running
  assign hit = trip && !bulk_erase_i;

  // events for the interrupt status, shared by the read mux and the sticky bits
  assign ev = '{
    ready_rise: brownout_ready_flag && !st_r.rdy_q,
    erase_abort: trip && bulk_erase_i && !st_r.trip_q,
    reset_event: hit && !st_r.trip_q
  };

  // start-up waits for a ready monitor and good supply in modes 11 and 10
  always_comb begin
    case (st_r.cfg.brownout_mode_select)
      brc_pkg::BRC_MODE_ON,
      brc_pkg::BRC_MODE_SLEEP_OFF: begin
        start_wait = !brownout_ready_flag || low;
      end
      default: begin
        start_wait = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // register read mux, evaluated in the setup cycle

  always_comb begin
    rd = 32'h0000_0000;
    rd_err = 1'b0;
    case (apb_i.paddr)
      `BRC_CFG_OFS: begin
        rd[`BRC_CFG_MODE_LSB +: 2] = st_r.cfg.brownout_mode_select;
        rd[`BRC_CFG_SOFT_BIT] = st_r.cfg.brownout_soft_enable;
        rd[`BRC_CFG_THR_LSB +: 4] = st_r.cfg.brownout_threshold;
      end
      `BRC_STAT_OFS: begin
        rd[`BRC_STAT_POR_N_BIT] = st_r.por_flag_n;
        rd[`BRC_STAT_CAUSE_N_BIT] = st_r.brownout_cause_flag_n;
        rd[`BRC_STAT_READY_BIT] = brownout_ready_flag;
        rd[`BRC_STAT_ACTIVE_BIT] = st_r.mon_en;
        rd[`BRC_STAT_RUN_BIT] = st_r.cpu_run;
      end
      `BRC_IRQ_STAT_OFS: begin
        // fold in the setup-cycle event so the read-clear cannot swallow it
        rd[2:0] = st_r.irq_st | ev;
      end
      `BRC_IRQ_MASK_OFS: begin
        rd[2:0] = st_r.irq_mask;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    st_nxt = st_r;

    // two-stage synchronisers for the analog pins
    st_nxt.sync_por = {st_r.sync_por[0], por_mon_i};
    st_nxt.sync_low = {st_r.sync_low[0], supply_low_i};
    st_nxt.sync_rdy = {st_r.sync_rdy[0], mon_ready_i};
    st_nxt.rdy_q = brownout_ready_flag;
    st_nxt.trip_q = trip;

    // one-cycle pulses default low
    st_nxt.pud_start = 1'b0;
    st_nxt.abort = 1'b0;

    // apb: no wait states, answer raised in the first access cycle
    st_nxt.pready = setup;
    if (setup) begin
      st_nxt.prdata = rd;
      st_nxt.pslverr = rd_err;
    end

    // software writes land at the completing access edge
    if (access && apb_i.pwrite) begin
      case (apb_i.paddr)
        `BRC_CFG_OFS: begin
          st_nxt.cfg.brownout_mode_select =
            brc_pkg::brc_mode_t'(apb_i.pwdata[`BRC_CFG_MODE_LSB +: 2]);
          st_nxt.cfg.brownout_soft_enable = apb_i.pwdata[`BRC_CFG_SOFT_BIT];
          st_nxt.cfg.brownout_threshold = apb_i.pwdata[`BRC_CFG_THR_LSB +: 4];
        end
        `BRC_STAT_OFS: begin
          // writing 1 re-arms a cause flag; hardware clears below still win
          if (apb_i.pwdata[`BRC_STAT_POR_N_BIT]) begin
            st_nxt.por_flag_n = 1'b1;
          end
          if (apb_i.pwdata[`BRC_STAT_CAUSE_N_BIT]) begin
            st_nxt.brownout_cause_flag_n = 1'b1;
          end
        end
        `BRC_IRQ_MASK_OFS: begin
          st_nxt.irq_mask = brc_pkg::brc_irq_t'(apb_i.pwdata[2:0]);
        end
        default: begin
        end
      endcase
    end

    // start-up sequencer
    case (st_r.fsm)
      brc_pkg::BRC_ST_HOLD: begin
        // timer only starts once power-on and brown-out both let go
        if (!por_act && !trip) begin
          st_nxt.fsm = brc_pkg::BRC_ST_WAIT;
          st_nxt.pud_start = 1'b1;
        end
      end
      brc_pkg::BRC_ST_WAIT: begin
        if (!start_wait) begin
          st_nxt.fsm = brc_pkg::BRC_ST_RUN;
        end
      end
      brc_pkg::BRC_ST_RUN: begin
        if (sleep_i) begin
          st_nxt.fsm = brc_pkg::BRC_ST_SLEEP;
        end
      end
      brc_pkg::BRC_ST_SLEEP: begin
        if (!sleep_i) begin
          if (st_r.cfg.brownout_mode_select == brc_pkg::BRC_MODE_SLEEP_OFF) begin
            st_nxt.fsm = brc_pkg::BRC_ST_WAKE;
          end else begin
            st_nxt.fsm = brc_pkg::BRC_ST_RUN;
          end
        end
      end
      brc_pkg::BRC_ST_WAKE: begin
        if (brownout_ready_flag) begin
          st_nxt.fsm = brc_pkg::BRC_ST_RUN;
        end
      end
      default: begin
        st_nxt.fsm = brc_pkg::BRC_ST_HOLD;
      end
    endcase

    // resets take priority over any sequencer step
    if (por_act) begin
      st_nxt.fsm = brc_pkg::BRC_ST_HOLD;
      st_nxt.por_flag_n = 1'b0;
    end else if (hit) begin
      st_nxt.fsm = brc_pkg::BRC_ST_HOLD;
      st_nxt.brownout_cause_flag_n = 1'b0;
    end

    // erase abort pulse; the sticky bit below keeps it for software
    st_nxt.abort = ev.erase_abort;

    // read clears the sticky status; a same-cycle event still lands
    if (access && !apb_i.pwrite && apb_i.paddr == `BRC_IRQ_STAT_OFS) begin
      st_nxt.irq_st = ev;
    end else begin
      st_nxt.irq_st = st_r.irq_st | ev;
    end
    st_nxt.irq = |(st_nxt.irq_st & st_nxt.irq_mask);

    // registered outputs
    st_nxt.mon_en = active;
    st_nxt.mon_hib = hibernate;
    st_nxt.thr = bulk_erase_i ? `BRC_THR_LOWEST : st_nxt.cfg.brownout_threshold;
    st_nxt.dev_reset = (st_nxt.fsm == brc_pkg::BRC_ST_HOLD);
    // the ready flag is already 1 whenever modes 11 or 10 reach run
    st_nxt.cpu_run = (st_nxt.fsm == brc_pkg::BRC_ST_RUN);
  end

  //////////////////////////////////////////////////////////////////////////////
  // dip filter

  brc_filter #(
    .FILT_CYC(FILT_CYC)
  ) u_filter (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .low_i(filt_low),
    .trip_o(trip)
  );

  //////////////////////////////////////////////////////////////////////////////
  // state register; reset is the power-on signal itself

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
      st_r.fsm <= brc_pkg::BRC_ST_HOLD;
      // assume power-on until the pin is seen low through both stages
      st_r.sync_por <= 2'h3;
      st_r.cfg.brownout_mode_select <= brc_pkg::brc_mode_t'(`BRC_CFG_MODE_RST);
      st_r.cfg.brownout_soft_enable <= `BRC_CFG_SOFT_RST;
      st_r.cfg.brownout_threshold <= `BRC_CFG_THR_RST;
      st_r.irq_mask <= brc_pkg::brc_irq_t'(`BRC_IRQ_MASK_RST);
      st_r.por_flag_n <= 1'b0;
      st_r.brownout_cause_flag_n <= 1'b1;
      st_r.dev_reset <= 1'b1;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign apb_o.prdata = st_r.prdata;
  assign apb_o.pready = st_r.pready;
  assign apb_o.pslverr = st_r.pslverr;
  assign mon_enable_o = st_r.mon_en;
  assign mon_hibernate_o = st_r.mon_hib;
  assign brownout_threshold_o = st_r.thr;
  assign dev_reset_o = st_r.dev_reset;
  assign cpu_run_o = st_r.cpu_run;
  assign power_up_delay_start_o = st_r.pud_start;
  assign erase_abort_o = st_r.abort;
  assign irq_o = st_r.irq;

endmodule

// >>> logic/brc_regs.svh
`ifndef BRC_REGS_SVH
`define BRC_REGS_SVH

// register byte offsets on the apb bus
`define BRC_CFG_OFS 8'h00
`define BRC_STAT_OFS 8'h04
`define BRC_IRQ_STAT_OFS 8'h08
`define BRC_IRQ_MASK_OFS 8'h0C

// configuration register fields
`define BRC_CFG_MODE_LSB 0
`define BRC_CFG_SOFT_BIT 2
`define BRC_CFG_THR_LSB 4

// status register fields
`define BRC_STAT_POR_N_BIT 0
`define BRC_STAT_CAUSE_N_BIT 1
`define BRC_STAT_READY_BIT 2
`define BRC_STAT_ACTIVE_BIT 3
`define BRC_STAT_RUN_BIT 4

// interrupt status and mask fields
`define BRC_IRQ_RESET_BIT 0
`define BRC_IRQ_ABORT_BIT 1
`define BRC_IRQ_READY_BIT 2

// reset values, and the lowest threshold forced during erase
`define BRC_CFG_MODE_RST 2'h3
`define BRC_CFG_SOFT_RST 1'h0
`define BRC_CFG_THR_RST 4'h0
`define BRC_IRQ_MASK_RST 3'h0
`define BRC_THR_LOWEST 4'h0

// timing: supply dip filter, rounded up to whole cycles
`define BRC_CLK_MHZ 200
`define BRC_FILT_NS 2000
`define BRC_FILT_CYC ((`BRC_FILT_NS * `BRC_CLK_MHZ + 999) / 1000)

`endif

// >>> logic/brc_pkg.sv
package brc_pkg;

  // monitor operating modes, as coded in the mode select field
  typedef enum logic [1:0] {
    BRC_MODE_OFF = 2'h0,
    BRC_MODE_SOFT = 2'h1,
    BRC_MODE_SLEEP_OFF = 2'h2,
    BRC_MODE_ON = 2'h3
  } brc_mode_t;

  // start-up sequencer states, one-hot
  typedef enum logic [4:0] {
    BRC_ST_HOLD = 5'h01,
    BRC_ST_WAIT = 5'h02,
    BRC_ST_RUN = 5'h04,
    BRC_ST_SLEEP = 5'h08,
    BRC_ST_WAKE = 5'h10
  } brc_state_t;

  typedef struct packed {
    logic [3:0] brownout_threshold;
    logic brownout_soft_enable;
    brc_mode_t brownout_mode_select;
  } brc_cfg_t;

  typedef struct packed {
    logic ready_rise;
    logic erase_abort;
    logic reset_event;
  } brc_irq_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } brc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } brc_apb_rsp_t;

endpackage

// >>> logic/brc_filter.sv
`timescale 1ns/1ps

// supply dip filter: trips only when the low indication outlasts the window
module brc_filter #(
  parameter int FILT_CYC = 400
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // filtered condition
  input wire logic low_i,
  output logic trip_o
);

  localparam int CW = $clog2(FILT_CYC + 2);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic trip;
  } brc_filt_st_t;

  brc_filt_st_t st_r;
  brc_filt_st_t st_nxt;

  generate
    if (FILT_CYC < 1) begin : g_bad
      $error("brc_filter: FILT_CYC must be at least 1");
    end
  endgenerate

  // count consecutive low cycles; any high cycle restarts the window
  always_comb begin
    st_nxt = st_r;
    if (!low_i) begin
      st_nxt.cnt = '0;
      st_nxt.trip = 1'b0;
    end else if (st_r.cnt > CW'(FILT_CYC)) begin
      st_nxt.trip = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= '0;
    end else if (ce_i) begin
      st_r <= st_nxt;
    end
  end

  assign trip_o = st_r.trip;

endmodule

// >>> bench/brc_checker.sv
`timescale 1ns/1ps
// port-level watcher for the brown-out reset control block
module brc_checker #(
  parameter int FILT_CYC = 400
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // inputs seen
  input wire brc_pkg::brc_apb_req_t apb_i,
  input wire logic por_mon_i,
  input wire logic supply_low_i,
  input wire logic bulk_erase_i,
  // outputs seen
  input wire brc_pkg::brc_apb_rsp_t apb_o,
  input wire logic mon_enable_o,
  input wire logic mon_hibernate_o,
  input wire logic [3:0] brownout_threshold_o,
  input wire logic dev_reset_o,
  input wire logic cpu_run_o,
  input wire logic power_up_delay_start_o,
  input wire logic erase_abort_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // wide enough to count past the filter window before saturating
  localparam int LW = $clog2(FILT_CYC + 8);
  logic [LW-1:0] low_run_r;
  logic [LW-1:0] low_run_nxt;
  //////////////////////////////
  // length of the current supply dip, saturating so long dips never wrap
  always_comb begin
    low_run_nxt = supply_low_i ? (low_run_r + LW'(~&low_run_r)) : '0;
  end
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_run_r <= '0;
    end else begin
      low_run_r <= low_run_nxt;
    end
  end
  //////////////////////////////
  // pins pass two flops and the sequencer one more: causes are looked at three back
  por_hold_a: assert property (por_mon_i |-> ##[1:4] dev_reset_o)
    else $error("power-on monitor did not hold reset");
  dip_filter_a: assert property ($rose(dev_reset_o) |-> $past(por_mon_i, 3)
    || int'($past(low_run_r, 3)) > FILT_CYC + 1)
    else $error("reset raised by a short dip");
  erase_thr_a: assert property ($past(bulk_erase_i) |-> brownout_threshold_o == 4'h0)
    else $error("threshold not lowest during erase");
  erase_on_a: assert property (bulk_erase_i && $past(bulk_erase_i) && !dev_reset_o
    |-> mon_enable_o && !mon_hibernate_o)
    else $error("monitor not forced on during erase");
  abort_norst_a: assert property (erase_abort_o |-> $past(bulk_erase_i)
    ##1 (!erase_abort_o && !dev_reset_o) [*3])
    else $error("erase abort wrong or followed by reset");
  run_gate_a: assert property ($past(por_mon_i, 3) |-> dev_reset_o && !cpu_run_o)
    else $error("execution allowed while power-on asserted");
  pud_start_a: assert property (power_up_delay_start_o
    |-> !$past(por_mon_i, 3) && $past(dev_reset_o) && !dev_reset_o)
    else $error("delay timer started before reset release");
  apb_ready_a: assert property (apb_i.psel && !apb_i.penable
    |=> apb_o.pready ##1 !apb_o.pready)
    else $error("bus answer not one cycle after setup");
endmodule

// >>> bench/brc_mon_model.sv
`timescale 1ns/1ps
// analog monitor stand-in: ready comes a while after power-up, and the
// comparator output is junk while the monitor is down
module brc_mon_model #(
  parameter int RDY_DLY = 6
) (
  // clock
  input wire logic ref_clk_i,
  // control from the block
  input wire logic mon_enable_i,
  input wire logic mon_hibernate_i,
  // supply conditions set by the bench
  input wire logic por_i,
  input wire logic dip_i,
  // monitor pins
  output logic por_mon_o,
  output logic supply_low_o,
  output logic mon_ready_o
);
  int cnt = 0;
  logic junk = 1'b0;
  //////////////////////////////
  // settle counter restarts whenever power to the monitor is cut
  always @(posedge ref_clk_i) begin
    cnt <= (mon_enable_i && !mon_hibernate_i) ? ((cnt < RDY_DLY) ? cnt + 1 : cnt) : 0;
    junk <= !junk;
  end
  assign mon_ready_o = (cnt >= RDY_DLY);
  assign supply_low_o = mon_ready_o ? dip_i : junk;
  assign por_mon_o = por_i;
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`include "brc_regs.svh"
// self-checking bench for the brown-out reset control block
module tb_top;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  brc_pkg::brc_apb_req_t apb_i = '0;
  brc_pkg::brc_apb_rsp_t apb_o;
  logic por_cmd = 1'b0;
  logic dip_cmd = 1'b0;
  logic sleep_i = 1'b0;
  logic bulk_erase_i = 1'b0;
  logic ce_i = 1'b1;
  logic por_mon_i, supply_low_i, mon_ready_i, mon_enable_o, mon_hibernate_o;
  logic dev_reset_o, cpu_run_o, power_up_delay_start_o, erase_abort_o, irq_o;
  logic [3:0] brownout_threshold_o;
  logic [31:0] rd;
  logic err;
  int pud_n = 0;
  int fail_count = 0;
  int n_compared = 0;
  //////////////////////////////
  // 200 MHz clock, and a tally of delay-timer starts
  always #2.5 ref_clk_i = !ref_clk_i;
  always @(posedge ref_clk_i) pud_n <= pud_n + int'(power_up_delay_start_o);
  // small filter window keeps the dip scenarios short
  brc_ctrl #(.FILT_CYC(4)) brc_ctrl_inst (
    .ref_clk_i, .reset_n_i, .ce_i, .apb_i, .apb_o, .por_mon_i,
    .supply_low_i, .mon_ready_i, .sleep_i, .bulk_erase_i, .mon_enable_o,
    .mon_hibernate_o, .brownout_threshold_o, .dev_reset_o, .cpu_run_o,
    .power_up_delay_start_o, .erase_abort_o, .irq_o);
  brc_mon_model brc_mon_model_inst (
    .ref_clk_i, .mon_enable_i(mon_enable_o), .mon_hibernate_i(mon_hibernate_o),
    .por_i(por_cmd), .dip_i(dip_cmd), .por_mon_o(por_mon_i),
    .supply_low_o(supply_low_i), .mon_ready_o(mon_ready_i));
  //////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic stall();
    fail_count++;
    $display("ERROR %0t: wait ran out", $time);
    conclude();
  endtask
  task automatic cy(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // one bus transfer; holds the request until pready is sampled high
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apb_i <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge ref_clk_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (apb_o.pready !== 1'b1 && n < 20);
    if (apb_o.pready !== 1'b1) begin
      stall();
    end
    rd = apb_o.prdata;
    err = apb_o.pslverr;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return cpu_run_o;
      1: return dev_reset_o;
      default: return erase_abort_o;
    endcase
  endfunction
  task automatic wait_on(input int w, input int lim);
    int n;
    n = 0;
    while (pick(w) !== 1'b1 && n < lim) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (pick(w) !== 1'b1) begin
      stall();
    end
  endtask
  //////////////////////////////
  // start-up in the default always-on mode, then register basics
  task automatic t_start();
    wait_on(0, 80);
    chk(mon_ready_i, 1'b1);
    chk(pud_n, 1);
    xfer(1'b0, `BRC_STAT_OFS, 32'h0);
    chk(rd, 32'h1E);
    xfer(1'b0, `BRC_CFG_OFS, 32'h0);
    chk(rd, 32'h3);
    xfer(1'b0, 8'h10, 32'h0);
    chk({err, rd[0]}, 2'h2);
    xfer(1'b1, `BRC_STAT_OFS, 32'h1);
    xfer(1'b0, `BRC_STAT_OFS, 32'h0);
    chk(rd[0], 1'b1);
  endtask
  // clock enable low freezes the sequencer although sleep is requested
  task automatic t_freeze();
    ce_i <= 1'b0;
    sleep_i <= 1'b1;
    cy(6);
    chk(cpu_run_o, 1'b1);
    ce_i <= 1'b1;
    cy(3);
    chk(cpu_run_o, 1'b0);
    sleep_i <= 1'b0;
    wait_on(0, 4);
  endtask
  // each mode awake and asleep; only the sleep-off mode stalls wake-up
  task automatic t_modes();
    logic [7:0] cf [5] = '{8'h50, 8'h51, 8'h55, 8'h52, 8'h53};
    logic [4:0] ex [5] = '{5'h00, 5'h09, 5'h16, 5'h15, 5'h16};
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, `BRC_CFG_OFS, {24'h0, cf[i]});
      cy(12);
      chk({mon_enable_o && !mon_hibernate_o, mon_hibernate_o}, ex[i][4:3]);
      xfer(1'b0, `BRC_STAT_OFS, 32'h0);
      chk(rd[2], ex[i][2]);
      sleep_i <= 1'b1;
      cy(12);
      chk({mon_enable_o && !mon_hibernate_o, mon_hibernate_o}, ex[i][1:0]);
      chk(cpu_run_o, 1'b0);
      sleep_i <= 1'b0;
      if (i == 3) begin
        cy(3);
        chk(cpu_run_o, 1'b0);
        wait_on(0, 40);
      end else begin
        wait_on(0, 4);
      end
    end
  endtask
  // short dip ignored, long dip resets with cause and interrupt
  task automatic t_brown();
    xfer(1'b1, `BRC_IRQ_MASK_OFS, 32'h1);
    dip_cmd <= 1'b1;
    cy(3);
    dip_cmd <= 1'b0;
    cy(10);
    chk(dev_reset_o, 1'b0);
    dip_cmd <= 1'b1;
    wait_on(1, 40);
    dip_cmd <= 1'b0;
    wait_on(0, 80);
    chk(irq_o, 1'b1);
    xfer(1'b0, `BRC_STAT_OFS, 32'h0);
    chk(rd[1], 1'b0);
    xfer(1'b0, `BRC_IRQ_STAT_OFS, 32'h0);
    chk(rd[0], 1'b1);
    cy(2);
    chk(irq_o, 1'b0);
    por_cmd <= 1'b1;
    wait_on(1, 10);
    por_cmd <= 1'b0;
    wait_on(0, 80);
    xfer(1'b0, `BRC_STAT_OFS, 32'h0);
    chk(rd[0], 1'b0);
  endtask
  // erase forces the monitor on at the lowest threshold; a dip only aborts
  task automatic t_erase();
    xfer(1'b1, `BRC_CFG_OFS, 32'h50);
    xfer(1'b1, `BRC_IRQ_MASK_OFS, 32'h0);
    chk(brownout_threshold_o, 4'h5);
    bulk_erase_i <= 1'b1;
    cy(12);
    chk(brownout_threshold_o, 4'h0);
    chk(mon_enable_o && !mon_hibernate_o, 1'b1);
    dip_cmd <= 1'b1;
    wait_on(2, 40);
    dip_cmd <= 1'b0;
    cy(4);
    chk({dev_reset_o, irq_o}, 2'h0);
    xfer(1'b1, `BRC_IRQ_MASK_OFS, 32'h2);
    cy(2);
    chk(irq_o, 1'b1);
    xfer(1'b0, `BRC_IRQ_STAT_OFS, 32'h0);
    chk(rd[1], 1'b1);
    bulk_erase_i <= 1'b0;
  endtask
  // main sequence
  initial begin
    cy(5);
    reset_n_i <= 1'b1;
    t_start();
    t_freeze();
    t_modes();
    t_brown();
    t_erase();
    conclude();
  end
endmodule

bind brc_ctrl brc_checker #(.FILT_CYC(FILT_CYC)) brc_checker_inst (
  .ref_clk_i, .reset_n_i, .apb_i, .por_mon_i, .supply_low_i, .bulk_erase_i,
  .apb_o, .mon_enable_o, .mon_hibernate_o, .brownout_threshold_o,
  .dev_reset_o, .cpu_run_o, .power_up_delay_start_o, .erase_abort_o);
